// >>> core/irq_router_pkg.sv
package irq_router_pkg;

    // ------------------------------------------------------------
    // Source layout, one bit per source in the enable, route and flag registers
    // ------------------------------------------------------------
    localparam int NUM_SRC = 24;        // All sources
    localparam int MAILBOXES = 4;       // Mailbox sources
    localparam int QUEUE_CONDS = 6;     // Message-queue conditions
    localparam int NUM_SOFT = 4;        // Software interrupts
    localparam int DATA_W = 32;         // Register data width
    localparam int ADDR_W = 8;          // Register address width

    localparam int SRC_PCI_BUS_ERR = 0;
    localparam int SRC_MASTER_PAR = 1;
    localparam int SRC_CPU_BUS_ERR = 2;
    localparam int SRC_DMA_CPU_ERR = 3;
    localparam int SRC_DMA_PCI_ERR = 4;
    localparam int SRC_DMA_RESET = 5;
    localparam int SRC_DMA_DONE = 6;
    localparam int SRC_PCI_SUMMARY = 7;
    localparam int SRC_MBOX0 = 8;       // Mailboxes 0..3 at 8..11
    localparam int SRC_CPU_PARITY = 12;
    localparam int SRC_POWER_CHG = 13;
    localparam int SRC_QUEUE0 = 14;     // Queue conditions at 14..19
    localparam int SRC_SOFT0 = 20;      // Software 0..3 at 20..23

    // ------------------------------------------------------------
    // Register offsets and reset values
    // ------------------------------------------------------------
    localparam logic [ADDR_W-1:0] OFF_IRQ_ENABLE = 8'h00;
    localparam logic [ADDR_W-1:0] OFF_IRQ_ROUTE = 8'h04;
    localparam logic [ADDR_W-1:0] OFF_IRQ_FLAG = 8'h08;
    localparam logic [ADDR_W-1:0] OFF_SOFT_TRIGGER = 8'h0C;

    localparam logic [NUM_SRC-1:0] RST_IRQ_ENABLE = 24'h000000;
    localparam logic [NUM_SRC-1:0] RST_IRQ_ROUTE = 24'h000000;
    localparam logic [NUM_SRC-1:0] SOFT_MASK = 24'hF00000;
    localparam logic ROUTE_TO_PCI = 1'b1;   // Route bit value for PCI

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic [ADDR_W-1:0] addr;    // Byte address
        logic [DATA_W-1:0] wdata;   // Write data
        logic              wr;      // Write strobe
        logic              rd;      // Read strobe
    } reg_req_s;

    typedef struct packed {
        logic                   pci_bus_err;
        logic                   master_parity_detect;
        logic                   cpu_bus_err;
        logic                   dma_cpu_err;
        logic                   dma_pci_err;
        logic                   dma_reset_flag;
        logic                   dma_done;
        logic                   cpu_parity_err;
        logic                   power_change;
        logic [QUEUE_CONDS-1:0] queue;
    } hw_events_s;

    typedef struct packed {
        logic detected_parity_err;
        logic signalled_sys_err;
        logic got_master_abort;
        logic got_target_abort;
        logic sent_target_abort;
    } pci_status_s;

endpackage

// >>> core/sticky_flag_bank.sv
`timescale 1ns/100ps
module sticky_flag_bank
    import irq_router_pkg::*;
#(
    parameter int WIDTH = NUM_SRC
) (
    input  wire logic             mclk_i,
    input  wire logic             sys_rst_i,
    input  wire logic [WIDTH-1:0] set_i,    // Source active, per bit
    input  wire logic [WIDTH-1:0] clr_i,    // Write-one-to-clear mask
    output logic      [WIDTH-1:0] flag_o    // Sticky flags
);

    logic [WIDTH-1:0] next_flag;    // Next flag values

    // ------------------------------------------------------------
    // Per-bit update
    // ------------------------------------------------------------
    // A source still active keeps its flag up through a clear
    for (genvar i = 0; i < WIDTH; i++) begin : g_bit
        always_comb begin
            next_flag[i] = set_i[i] | (flag_o[i] & ~clr_i[i]);
        end
    end

    // Registers only
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            flag_o <= '0;
        end else begin
            flag_o <= next_flag;
        end
    end

    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (sys_rst_i);

    set_beats_clear_a : assert property (
        (set_i & clr_i) != '0 |=> (flag_o & $past(set_i & clr_i)) == $past(set_i & clr_i)
    ) else $error("Clear won over an active source");

endmodule

// >>> core/pci_summary_detect.sv
`timescale 1ns/100ps
module pci_summary_detect
    import irq_router_pkg::*;
(
    input  wire logic        mclk_i,
    input  wire logic        sys_rst_i,
    input  wire pci_status_s status_i,  // PCI command/status bits
    output logic             summary_o  // Any summary bit set
);

    logic next_summary;     // Next summary level

    // ------------------------------------------------------------
    // Summary of five status bits
    // ------------------------------------------------------------
    // Master parity detect is left out: it has a source of its own
    always_comb begin
        next_summary = |status_i;
    end

    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            summary_o <= 1'b0;
        end else begin
            summary_o <= next_summary;
        end
    end

    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (sys_rst_i);

    summary_follows_a : assert property (
        status_i != '0 |=> summary_o
    ) else $error("Summary missed a PCI status bit");

endmodule

// >>> core/event_and_soft_interrupt_router.sv
`timescale 1ns/100ps
module event_and_soft_interrupt_router
    import irq_router_pkg::*;
(
    input  wire logic                 mclk_i,
    input  wire logic                 sys_rst_i,
    input  wire reg_req_s             reg_req_i,
    output logic     [DATA_W-1:0]     reg_rdata_o,
    input  wire hw_events_s           hw_evt_i,
    input  wire pci_status_s          pci_status_i,
    input  wire logic [MAILBOXES-1:0] mbox_wr_pci_i,
    input  wire logic [MAILBOXES-1:0] mbox_wr_cpu_i,
    output logic                      pci_irq_o,
    output logic                      cpu_side_irq_pin_o,
    output logic                      irq_o
);

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    logic [NUM_SRC-1:0]   irq_enable_reg;       // Enable, soft bits zero
    logic [NUM_SRC-1:0]   next_irq_enable_reg;
    logic [NUM_SRC-1:0]   irq_route_reg;        // One means PCI
    logic [NUM_SRC-1:0]   next_irq_route_reg;
    logic [NUM_SRC-1:0]   irq_flag;             // Sticky status flags
    logic [NUM_SRC-1:0]   src_set;              // Set term per source
    logic [NUM_SRC-1:0]   flag_clr;             // Clear mask from software
    logic [NUM_SRC-1:0]   irq_gate;             // Enable or soft bit
    logic [NUM_SRC-1:0]   routed_pci;           // Pending toward PCI
    logic [NUM_SRC-1:0]   routed_cpu;           // Pending toward processor
    logic [MAILBOXES-1:0] mbox_set;             // Mailbox set terms
    logic [NUM_SOFT-1:0]  soft_set;             // Software trigger bits
    logic                 pci_summary_active;   // Registered summary
    logic [DATA_W-1:0]    next_reg_rdata;
    logic                 next_pci_irq;
    logic                 next_cpu_irq;
    logic                 next_irq;

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    // Full address match; used by writes, reads and checks
    function automatic logic hit(input logic [ADDR_W-1:0] addr,
                                 input logic [ADDR_W-1:0] off);
        hit = (addr == off);
    endfunction

    // ------------------------------------------------------------
    // Summary of the PCI status bits
    // ------------------------------------------------------------
    pci_summary_detect u_summary (
        .mclk_i    (mclk_i),
        .sys_rst_i (sys_rst_i),
        .status_i  (pci_status_i),
        .summary_o (pci_summary_active)
    );

    // ------------------------------------------------------------
    // Mailbox set terms
    // ------------------------------------------------------------
    // A mailbox routed to one bus only counts writes from the other
    // bus, so a processor writing its own mailbox never wakes itself
    for (genvar m = 0; m < MAILBOXES; m++) begin : g_mbox
        always_comb begin
            if (irq_route_reg[SRC_MBOX0 + m] == ROUTE_TO_PCI) begin
                mbox_set[m] = mbox_wr_cpu_i[m];
            end else begin
                mbox_set[m] = mbox_wr_pci_i[m];
            end
        end
    end

    // ------------------------------------------------------------
    // Software triggers and clears
    // ------------------------------------------------------------
    // Trigger bits are not stored: writing a one sets the flag,
    // and the flag itself keeps the line up until cleared
    always_comb begin
        soft_set = '0;
        flag_clr = '0;
        if (reg_req_i.wr && hit(reg_req_i.addr, OFF_SOFT_TRIGGER)) begin
            soft_set = reg_req_i.wdata[NUM_SOFT-1:0];
        end
        if (reg_req_i.wr && hit(reg_req_i.addr, OFF_IRQ_FLAG)) begin
            flag_clr = reg_req_i.wdata[NUM_SRC-1:0];
        end
    end

    // ------------------------------------------------------------
    // Source vector
    // ------------------------------------------------------------
    // Hardware sources are levels or pulses from blocks on this clock;
    // a level held high re-sets its flag every cycle, so software has
    // to clear the source before the flag
    always_comb begin
        src_set = '0;
        src_set[SRC_PCI_BUS_ERR] = hw_evt_i.pci_bus_err;
        src_set[SRC_MASTER_PAR] = hw_evt_i.master_parity_detect;
        src_set[SRC_CPU_BUS_ERR] = hw_evt_i.cpu_bus_err;
        src_set[SRC_DMA_CPU_ERR] = hw_evt_i.dma_cpu_err;
        src_set[SRC_DMA_PCI_ERR] = hw_evt_i.dma_pci_err;
        src_set[SRC_DMA_RESET] = hw_evt_i.dma_reset_flag;
        src_set[SRC_DMA_DONE] = hw_evt_i.dma_done;
        src_set[SRC_PCI_SUMMARY] = pci_summary_active;
        src_set[SRC_MBOX0 +: MAILBOXES] = mbox_set;
        src_set[SRC_CPU_PARITY] = hw_evt_i.cpu_parity_err;
        src_set[SRC_POWER_CHG] = hw_evt_i.power_change;
        src_set[SRC_QUEUE0 +: QUEUE_CONDS] = hw_evt_i.queue;
        src_set[SRC_SOFT0 +: NUM_SOFT] = soft_set;
    end

    // ------------------------------------------------------------
    // Status flags
    // ------------------------------------------------------------
    sticky_flag_bank #(
        .WIDTH (NUM_SRC)
    ) u_flags (
        .mclk_i    (mclk_i),
        .sys_rst_i (sys_rst_i),
        .set_i     (src_set),
        .clr_i     (flag_clr),
        .flag_o    (irq_flag)
    );

    // ------------------------------------------------------------
    // Enable and route registers
    // ------------------------------------------------------------
    // Soft positions of the enable register are forced to zero
    always_comb begin
        next_irq_enable_reg = irq_enable_reg;
        next_irq_route_reg = irq_route_reg;
        if (reg_req_i.wr && hit(reg_req_i.addr, OFF_IRQ_ENABLE)) begin
            next_irq_enable_reg = reg_req_i.wdata[NUM_SRC-1:0] & ~SOFT_MASK;
        end
        if (reg_req_i.wr && hit(reg_req_i.addr, OFF_IRQ_ROUTE)) begin
            next_irq_route_reg = reg_req_i.wdata[NUM_SRC-1:0];
        end
    end

    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            irq_enable_reg <= RST_IRQ_ENABLE;
            irq_route_reg <= RST_IRQ_ROUTE;
        end else begin
            irq_enable_reg <= next_irq_enable_reg;
            irq_route_reg <= next_irq_route_reg;
        end
    end

    // ------------------------------------------------------------
    // Interrupt outputs
    // ------------------------------------------------------------
    // Each output is its own reduction with no feedback into the bus
    // or the other output, so a pending line on one side never holds
    // off traffic on the other
    always_comb begin
        irq_gate = irq_enable_reg | SOFT_MASK;
        routed_pci = irq_flag & irq_gate & irq_route_reg;
        routed_cpu = irq_flag & irq_gate & ~irq_route_reg;
        next_pci_irq = |routed_pci;
        next_cpu_irq = |routed_cpu;
        next_irq = next_pci_irq | next_cpu_irq;
    end

    // Registered so the pins are glitch free; costs one cycle
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            pci_irq_o <= 1'b0;
            cpu_side_irq_pin_o <= 1'b0;
            irq_o <= 1'b0;
        end else begin
            pci_irq_o <= next_pci_irq;
            cpu_side_irq_pin_o <= next_cpu_irq;
            irq_o <= next_irq;
        end
    end

    // ------------------------------------------------------------
    // Read port
    // ------------------------------------------------------------
    // Data stands only in the cycle after the strobe, else zero;
    // unmapped offsets read zero
    always_comb begin
        next_reg_rdata = '0;
        if (reg_req_i.rd) begin
            if (hit(reg_req_i.addr, OFF_IRQ_ENABLE)) begin
                next_reg_rdata = DATA_W'(irq_enable_reg);
            end else if (hit(reg_req_i.addr, OFF_IRQ_ROUTE)) begin
                next_reg_rdata = DATA_W'(irq_route_reg);
            end else if (hit(reg_req_i.addr, OFF_IRQ_FLAG)) begin
                next_reg_rdata = DATA_W'(irq_flag);
            end else if (hit(reg_req_i.addr, OFF_SOFT_TRIGGER)) begin
                next_reg_rdata = DATA_W'(irq_flag[SRC_SOFT0 +: NUM_SOFT]);
            end else begin
                next_reg_rdata = '0;
            end
        end
    end

    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            reg_rdata_o <= '0;
        end else begin
            reg_rdata_o <= next_reg_rdata;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (sys_rst_i);

    // Which side wrote each mailbox, worked out from the route bits
    // alone (one means PCI), so the mailbox checks do not simply
    // repeat the set mux that they guard
    logic [MAILBOXES-1:0] mbox_route;       // Mailbox route bits
    logic [MAILBOXES-1:0] mbox_opp_wr;      // Write from the far bus
    logic [MAILBOXES-1:0] mbox_same_wr;     // Write from the own bus

    // Checker helper only; feeds no design logic
    always_comb begin
        mbox_route = irq_route_reg[SRC_MBOX0 +: MAILBOXES];
        mbox_opp_wr = (mbox_wr_cpu_i & mbox_route) | (mbox_wr_pci_i & ~mbox_route);
        mbox_same_wr = (mbox_wr_pci_i & mbox_route) | (mbox_wr_cpu_i & ~mbox_route);
    end

    sequence soft0_write_s;
        reg_req_i.wr && hit(reg_req_i.addr, OFF_SOFT_TRIGGER)
            && reg_req_i.wdata[0];
    endsequence

    sequence no_flag_write_s;
        !(reg_req_i.wr && hit(reg_req_i.addr, OFF_IRQ_FLAG));
    endsequence

    enable_gate_a : assert property (
        (irq_flag & irq_gate) == '0 |=> !pci_irq_o && !cpu_side_irq_pin_o
    ) else $error("Output raised with no enabled flag");

    route_pci_a : assert property (
        |(irq_flag & irq_gate & irq_route_reg) |=> pci_irq_o
    ) else $error("PCI output missed a routed flag");

    route_cpu_a : assert property (
        |(irq_flag & irq_gate & ~irq_route_reg) |=> cpu_side_irq_pin_o
    ) else $error("Processor output missed a routed flag");

    flag_readback_a : assert property (
        reg_req_i.rd && hit(reg_req_i.addr, OFF_IRQ_FLAG)
            |=> reg_rdata_o == DATA_W'($past(irq_flag))
    ) else $error("Flag read returned wrong value");

    hw_sets_flag_a : assert property (
        src_set != '0 |=> (irq_flag & $past(src_set)) == $past(src_set)
    ) else $error("Active source did not set its flag");

    w1c_clear_a : assert property (
        reg_req_i.wr && hit(reg_req_i.addr, OFF_IRQ_FLAG) && src_set == '0
            |=> (irq_flag & $past(reg_req_i.wdata[NUM_SRC-1:0])) == '0
    ) else $error("Write of one did not clear flag");

    zero_keeps_a : assert property (
        reg_req_i.wr && hit(reg_req_i.addr, OFF_IRQ_FLAG)
            |=> (irq_flag & $past(irq_flag & ~reg_req_i.wdata[NUM_SRC-1:0]))
                == $past(irq_flag & ~reg_req_i.wdata[NUM_SRC-1:0])
    ) else $error("Write of zero disturbed a flag");

    soft_fire_a : assert property (
        soft0_write_s ##1 no_flag_write_s
            |-> ##1 irq_flag[SRC_SOFT0]
                && (irq_route_reg[SRC_SOFT0] ? pci_irq_o : cpu_side_irq_pin_o)
    ) else $error("Software interrupt did not fire");

    soft_hold_a : assert property (
        |(irq_flag[SRC_SOFT0 +: NUM_SOFT] & irq_route_reg[SRC_SOFT0 +: NUM_SOFT]) |=> pci_irq_o
    ) else $error("Software interrupt dropped while flagged");

    summary_flag_a : assert property (
        pci_status_i != '0 |-> ##2 irq_flag[SRC_PCI_SUMMARY]
    ) else $error("Summary did not set its flag");

    mbox_same_side_a : assert property (
        mbox_same_wr != '0 && mbox_opp_wr == '0 && irq_flag[SRC_MBOX0 +: MAILBOXES] == '0
            |=> irq_flag[SRC_MBOX0 +: MAILBOXES] == '0
    ) else $error("Same-bus mailbox write set flag");

    dma_reset_hold_a : assert property (
        hw_evt_i.dma_reset_flag |=> irq_flag[SRC_DMA_RESET]
    ) else $error("DMA reset flag cleared while source active");

    mbox_far_side_a : assert property (
        mbox_opp_wr != '0
            |=> (irq_flag[SRC_MBOX0 +: MAILBOXES] & $past(mbox_opp_wr)) == $past(mbox_opp_wr)
    ) else $error("Far-bus mailbox write missed its flag");

    soft_trigger_a : assert property (
        reg_req_i.wr && hit(reg_req_i.addr, OFF_SOFT_TRIGGER)
            |=> (irq_flag[SRC_SOFT0 +: NUM_SOFT] & $past(reg_req_i.wdata[NUM_SOFT-1:0]))
                == $past(reg_req_i.wdata[NUM_SOFT-1:0])
    ) else $error("Software trigger did not set its flag");

    soft_no_enable_a : assert property (
        reg_req_i.rd && hit(reg_req_i.addr, OFF_IRQ_ENABLE)
            |=> reg_rdata_o[SRC_SOFT0 +: NUM_SOFT] == '0
    ) else $error("Software enable bits read back set");

    // Read data must not linger, or a poll would see stale flags
    rdata_idle_a : assert property (
        !reg_req_i.rd |=> reg_rdata_o == '0
    ) else $error("Read data stood outside its cycle");

    // Pins drop one cycle after the last routed flag goes
    pci_release_a : assert property (
        (irq_flag & irq_gate & irq_route_reg) == '0 |=> !pci_irq_o
    ) else $error("PCI output held with nothing routed");

    cpu_release_a : assert property (
        (irq_flag & irq_gate & ~irq_route_reg) == '0 |=> !cpu_side_irq_pin_o
    ) else $error("Processor output held with nothing routed");

    combined_out_a : assert property (
        irq_o == (pci_irq_o || cpu_side_irq_pin_o)
    ) else $error("Combined output differs from the two lines");

endmodule

// >>> bench/event_source_model.sv
`timescale 1ns/100ps
// ----------------------------------------------------------------
// Far side: source condition bits of the other bridge blocks
// ----------------------------------------------------------------
module event_source_model
    import irq_router_pkg::*;
(
    input  wire logic        mclk_i,
    input  wire logic        sys_rst_i,
    input  wire hw_events_s  raise_i,     // Event seen, one-cycle pulse
    input  wire hw_events_s  drop_i,      // Software cleared the source bit
    input  wire pci_status_s st_raise_i,  // Status bit set on the bus
    input  wire pci_status_s st_drop_i,   // Status bit written off
    output hw_events_s       evt_o,       // Held source conditions
    output pci_status_s      st_o         // Held PCI status bits
);
    // Source bits stay set until software clears them at the source,
    // so a flag cleared before its source is set again by the device
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            evt_o <= '0;
            st_o  <= '0;
        end else begin
            evt_o <= (evt_o | raise_i) & ~drop_i;
            st_o  <= (st_o | st_raise_i) & ~st_drop_i;
        end
    end
endmodule

// >>> bench/tb_top.sv
`timescale 1ns/100ps
module tb_top;
    import irq_router_pkg::*;
    logic        mclk_i;
    logic        sys_rst_i;
    reg_req_s    req;          // Register bus request
    logic [31:0] rdata;        // Read data
    hw_events_s  raise, drop;  // Source commands to the model
    pci_status_s st_up, st_dn; // Status commands to the model
    hw_events_s  evt;          // Held hardware sources
    pci_status_s st;           // Held PCI status
    logic [3:0]  mb_pci;       // Mailbox written from PCI
    logic [3:0]  mb_cpu;       // Mailbox written from processor
    logic        pci_irq, cpu_irq, irq;
    int          num_errors, num_checks, cycles, s;

    event_source_model far (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .raise_i(raise),
        .drop_i(drop), .st_raise_i(st_up), .st_drop_i(st_dn), .evt_o(evt), .st_o(st));
    event_and_soft_interrupt_router dut (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i),
        .reg_req_i(req), .reg_rdata_o(rdata), .hw_evt_i(evt), .pci_status_i(st),
        .mbox_wr_pci_i(mb_pci), .mbox_wr_cpu_i(mb_cpu), .pci_irq_o(pci_irq),
        .cpu_side_irq_pin_o(cpu_irq), .irq_o(irq));

    // ------------------------------------------------------------
    // Clock and hang guard
    // ------------------------------------------------------------
    initial begin
        mclk_i = 1'b0;
        forever #2 mclk_i = ~mclk_i;
    end
    // Whole run is about seven hundred cycles; the ceiling leaves margin
    always @(posedge mclk_i) begin
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            stop_test();
        end
    end

    // ------------------------------------------------------------
    // Compare and bus tasks
    // ------------------------------------------------------------
    task automatic chk_word(input string n, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            num_errors++;
            $display("unexpected %s: expected %h seen %h", n, e, g);
        end
    endtask
    // Pins in order PCI, processor, combined
    task automatic chk_pins(input logic p, input logic c);
        num_checks++;
        if ({pci_irq, cpu_irq, irq} !== {p, c, p | c}) begin
            num_errors++;
            $display("unexpected pins: expected %b seen %b", {p, c, p | c},
                     {pci_irq, cpu_irq, irq});
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk_i);
        req.wr    <= 1'b1;
        req.addr  <= a;
        req.wdata <= d;
        @(posedge mclk_i);
        req.wr <= 1'b0;
    endtask
    // Data stands only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge mclk_i);
        req.rd   <= 1'b1;
        req.addr <= a;
        @(posedge mclk_i);
        req.rd <= 1'b0;
        #1;
        chk_word($sformatf("read %h", a), e, rdata);
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge mclk_i);
        #1;
    endtask
    // Index below 15 is a hardware source bit, 15 and up a status bit
    task automatic src(input bit up, input int i);
        @(posedge mclk_i);
        if (i < 15 && up) raise <= hw_events_s'(15'h0001 << i);
        if (i < 15 && !up) drop <= hw_events_s'(15'h0001 << i);
        if (i >= 15 && up) st_up <= pci_status_s'(5'h01 << (i - 15));
        if (i >= 15 && !up) st_dn <= pci_status_s'(5'h01 << (i - 15));
        @(posedge mclk_i);
        raise <= '0;
        drop  <= '0;
        st_up <= '0;
        st_dn <= '0;
    endtask
    // Hardware struct bit to flag position
    function automatic int src_of(input int i);
        if (i < 6) return i + 14;
        if (i == 6) return 13;
        if (i == 7) return 12;
        return 14 - i;
    endfunction
    task automatic stop_test();
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        sys_rst_i = 1'b1;
        req = '0;
        {raise, drop, st_up, st_dn} = '0;
        {mb_pci, mb_cpu} = 8'h00;
        repeat (2) @(posedge mclk_i);
        sys_rst_i <= 1'b0;
        // Reset values and an unmapped place
        for (int a = 0; a <= 16; a += 4) rd(8'(a), 32'h0);
        chk_pins(1'b0, 1'b0);
        // Software bits carry no enable; route covers all sources
        wr(8'h00, 32'hFFFFFFFF);
        rd(8'h00, 32'h000FFFFF);
        wr(8'h04, 32'hFFFFFFFF);
        rd(8'h04, 32'h00FFFFFF);
        // Disabled source logs its flag but drives no pin
        wr(8'h00, 32'h0);
        src(1, 6);
        settle(3);
        rd(8'h08, 32'h00002000);
        chk_pins(1'b0, 1'b0);
        src(0, 6);
        wr(8'h08, 32'h00002000);
        // Every hardware source, alternating routes
        for (int i = 0; i < 15; i++) begin
            s = src_of(i);
            wr(8'h00, 32'h1 << s);
            wr(8'h04, (i % 2) ? 32'h1 << s : 32'h0);
            src(1, i);
            settle(3);
            rd(8'h08, 32'h1 << s);
            chk_pins(1'(i % 2), !(i % 2));
            wr(8'h08, 32'h1 << s);
            rd(8'h08, 32'h1 << s);
            src(0, i);
            wr(8'h08, 32'h1 << s);
            rd(8'h08, 32'h0);
            settle(3);
            chk_pins(1'b0, 1'b0);
        end
        // Each PCI status bit feeds the summary source
        wr(8'h00, 32'h80);
        wr(8'h04, 32'h80);
        for (int j = 15; j < 20; j++) begin
            src(1, j);
            settle(4);
            rd(8'h08, 32'h80);
            chk_pins(1'b1, 1'b0);
            src(0, j);
            wr(8'h08, 32'h80);
            settle(3);
            chk_pins(1'b0, 1'b0);
        end
        // Mailboxes fire only on writes from the opposite bus
        for (int m = 0; m < 4; m++) begin
            wr(8'h00, 32'h100 << m);
            wr(8'h04, (m % 2) ? 32'h0 : 32'h100 << m);
            @(posedge mclk_i);
            mb_pci <= (m % 2) ? 4'h0 : 4'h1 << m;
            mb_cpu <= (m % 2) ? 4'h1 << m : 4'h0;
            @(posedge mclk_i);
            {mb_pci, mb_cpu} <= 8'h00;
            settle(3);
            rd(8'h08, 32'h0);
            @(posedge mclk_i);
            mb_pci <= (m % 2) ? 4'h1 << m : 4'h0;
            mb_cpu <= (m % 2) ? 4'h0 : 4'h1 << m;
            @(posedge mclk_i);
            {mb_pci, mb_cpu} <= 8'h00;
            settle(3);
            rd(8'h08, 32'h100 << m);
            chk_pins(!(m % 2), 1'(m % 2));
            wr(8'h08, 32'h100 << m);
            settle(3);
            chk_pins(1'b0, 1'b0);
        end
        // Software bits with every enable off
        wr(8'h00, 32'h0);
        for (int k = 0; k < 4; k++) begin
            wr(8'h04, (k % 2) ? 32'h100000 << k : 32'h0);
            wr(8'h0C, 32'h1 << k);
            settle(3);
            rd(8'h08, 32'h100000 << k);
            rd(8'h0C, 32'h1 << k);
            chk_pins(1'(k % 2), !(k % 2));
            wr(8'h08, 32'h0);
            settle(3);
            rd(8'h08, 32'h100000 << k);
            chk_pins(1'(k % 2), !(k % 2));
            wr(8'h08, 32'h100000 << k);
            rd(8'h08, 32'h0);
            settle(3);
            chk_pins(1'b0, 1'b0);
        end
        stop_test();
    end
endmodule
